// file: logic/rxr_top.sv
// rxr_top: four channel receive recovery, line code selection and loss of signal
// assumes: slicer, master clock and transmit pins arrive asynchronously; register port on clk
//
// Behaviour
// - recovery loop runs at sixteen oversample phases per line bit.
// - select bit 0 gives recovered clock and retimed nrz data per rail mode.
// - select bit 1 passes raw sliced rails; clock output is their xor.
// - master clock held high forces raw dual rail on every channel.
// - single rail uses global code: 0/pin low B8ZS/HDB3, 1/pin high AMI.
// - override bit set takes code from the channel code bit instead.
// - dual rail bypasses decoding and ignores every code setting.
// - loss output high while loss declared; alarm register shows it.
// - loss detection and clearing each raise an interrupt, masked per bit by the enable register.
// - loss declared after 175, 32 or 2048 zero bits per criterion.
// - T1 clears on 16 marks in 128 bits, no zero run over 99.
// - E1 clears on 4 marks in 32 bits, no zero run over 15.
// - host mode offers three criteria; hardware mode only G.775 and T1.
// - during loss outside raw mode, AIS bit picks recovered data and clock or all ones plus master clock.
`timescale 1ns/1ps
module rxr_top #(
   parameter int MCLK_STUCK = rxr_pkg::MCLK_STUCK_CYCLES
) (
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       nrst,
   // register port
   input  wire logic [rxr_pkg::ADDR_W-1:0] addr,
   input  wire logic [rxr_pkg::DATA_W-1:0] wdata,
   input  wire logic                       wr,
   input  wire logic                       rd,
   output logic      [rxr_pkg::DATA_W-1:0] rdata,
   // pins: mode and master clock
   input  wire logic                       hw_mode_in,
   input  wire logic                       code_pin_in,
   input  wire logic                       master_clock_in,
   // pins: slicer and transmit side
   input  wire logic [rxr_pkg::NCH-1:0]    slicer_pos_in,
   input  wire logic [rxr_pkg::NCH-1:0]    slicer_neg_in,
   input  wire logic                       tx_clock_in,
   input  wire logic [rxr_pkg::NCH-1:0]    tx_negative_in,
   // receive outputs
   output logic      [rxr_pkg::NCH-1:0]    recovered_clock_out,
   output logic      [rxr_pkg::NCH-1:0]    rx_positive_out,
   output logic      [rxr_pkg::NCH-1:0]    rx_negative_out,
   output logic      [rxr_pkg::NCH-1:0]    rx_single_data_out,
   output logic      [rxr_pkg::NCH-1:0]    loss_of_signal_out,
   // interrupt
   output logic                            irq
);
   import rxr_pkg::*;

   localparam int SYNC_W = 4 + 3 * NCH;

   // two-flop synchronisers for every pin input
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= {hw_mode_in, code_pin_in, master_clock_in, tx_clock_in,
                     slicer_pos_in, slicer_neg_in, tx_negative_in};
         sync2_q <= sync1_q;
      end
   end

   logic           hw_s;
   logic           code_pin_s;
   logic           mclk_s;
   logic           txclk_s;
   logic [NCH-1:0] pos_s;
   logic [NCH-1:0] neg_s;
   logic [NCH-1:0] tdn_s;
   assign {hw_s, code_pin_s, mclk_s, txclk_s, pos_s, neg_s, tdn_s} = sync2_q;

   // edge finders on synchronised clocks
   logic mclk_d1_q;
   logic txclk_d1_q;
   logic tick;
   logic tx_edge;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mclk_d1_q  <= 1'b0;
         txclk_d1_q <= 1'b0;
      end else begin
         mclk_d1_q  <= mclk_s;
         txclk_d1_q <= txclk_s;
      end
   end
   assign tick    = mclk_s & ~mclk_d1_q;
   assign tx_edge = txclk_s & ~txclk_d1_q;

   // master clock held high is seen as no edge for MCLK_STUCK cycles
   logic [15:0] stuck_cnt_q;
   logic        mclk_high_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stuck_cnt_q <= 16'h0000;
         mclk_high_q <= 1'b0;
      end else if (tick || !mclk_s) begin
         stuck_cnt_q <= 16'h0000;
         mclk_high_q <= 1'b0;
      end else if (stuck_cnt_q == 16'(MCLK_STUCK)) begin
         mclk_high_q <= 1'b1;
      end else begin
         stuck_cnt_q <= stuck_cnt_q + 16'h0001;
      end
   end

   // registers
   rxr_gcfg_s      gcfg_q;
   logic [NCH-1:0] crs_q;
   logic [NCH-1:0] sing_q;
   logic [NCH-1:0] ccode_q;
   logic [7:0]     int_en_q;
   logic [7:0]     int_st_q;
   logic [NCH-1:0] los_w;
   logic [NCH-1:0] los_d1_q;
   logic [7:0]     int_ev;
   logic [7:0]     int_clr;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gcfg_q   <= rxr_gcfg_s'(GCF_RESET[3:0]);
         crs_q    <= CH_RESET;
         sing_q   <= CH_RESET;
         ccode_q  <= CH_RESET;
         int_en_q <= 8'h00;
      end else if (wr) begin
         unique case (addr)
            REG_GLOBAL_CONFIG: begin
               gcfg_q.code   <= wdata[GCF_CODE_POS];
               gcfg_q.etsi   <= wdata[GCF_ETSI_POS];
               gcfg_q.t1     <= wdata[GCF_T1_POS];
               gcfg_q.ais_en <= wdata[GCF_AIS_POS];
            end
            REG_RECOVERY_SELECT:      crs_q    <= wdata[NCH-1:0];
            REG_SINGLE_RAIL_OVERRIDE: sing_q   <= wdata[NCH-1:0];
            REG_CHANNEL_CODE:         ccode_q  <= wdata[NCH-1:0];
            REG_INT_ENABLE:           int_en_q <= wdata;
            default: ;
         endcase
      end
   end

   // events: low nibble loss declared, high nibble loss cleared
   assign int_ev  = {los_d1_q & ~los_w, los_w & ~los_d1_q};
   assign int_clr = (wr && addr == REG_INT_CLEAR) ? wdata : 8'h00;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         los_d1_q <= CH_RESET;
         int_st_q <= 8'h00;
         irq      <= 1'b0;
      end else begin
         los_d1_q <= los_w;
         // a new event wins over a clear in the same cycle
         int_st_q <= (int_st_q & ~int_clr) | int_ev;
         irq      <= |(((int_st_q & ~int_clr) | int_ev) & int_en_q);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= 8'h00;
      end else if (rd) begin
         unique case (addr)
            REG_GLOBAL_CONFIG:        rdata <= {4'h0, gcfg_q};
            REG_RECOVERY_SELECT:      rdata <= {4'h0, crs_q};
            REG_SINGLE_RAIL_OVERRIDE: rdata <= {4'h0, sing_q};
            REG_CHANNEL_CODE:         rdata <= {4'h0, ccode_q};
            REG_LOS_STATUS:           rdata <= {4'h0, los_w};
            REG_INT_STATUS:           rdata <= int_st_q;
            REG_INT_ENABLE:           rdata <= int_en_q;
            default:                  rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   // hardware mode offers no ETSI criterion and takes the code from the pin
   logic etsi_eff;
   logic gcode_eff;
   assign etsi_eff  = gcfg_q.etsi & ~hw_s & ~gcfg_q.t1;
   assign gcode_eff = hw_s ? code_pin_s : gcfg_q.code;

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : gen_ch
         logic       stb;
         logic       bpos;
         logic       bneg;
         logic       rclk_rec;
         logic [4:0] tdn_cnt_q;
         logic       single;
         logic       raw;
         logic       ami;
         logic       lastpos_q;
         logic [3:0] dly_q;
         logic       kill_q;
         logic       viol;
         logic       ais_ph_q;
         rxr_chout_s o_d;

         rxr_cdr u_cdr (
            .clk     (clk),
            .nrst    (nrst),
            .tick    (tick),
            .pos     (pos_s[g]),
            .neg     (neg_s[g]),
            .bit_stb (stb),
            .bit_pos (bpos),
            .bit_neg (bneg),
            .rclk    (rclk_rec)
         );

         rxr_los u_los (
            .clk     (clk),
            .nrst    (nrst),
            .t1      (gcfg_q.t1),
            .etsi    (etsi_eff),
            .bit_stb (stb),
            .mark    (bpos | bneg),
            .los     (los_w[g])
         );

         // single rail mode 1: transmit negative high beyond 16 transmit clocks
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               tdn_cnt_q <= 5'h00;
            end else if (tx_edge) begin
               if (!tdn_s[g]) begin
                  tdn_cnt_q <= 5'h00;
               end else if (tdn_cnt_q <= TDN_HIGH_EDGES) begin
                  tdn_cnt_q <= tdn_cnt_q + 5'h01;
               end
            end
         end

         assign raw    = crs_q[g] | mclk_high_q;
         assign single = !raw && ((tdn_cnt_q > TDN_HIGH_EDGES) || sing_q[g]);
         assign ami    = sing_q[g] ? ccode_q[g] : gcode_eff;
         assign viol   = (bpos | bneg) && (bpos == lastpos_q);

         // decoder: a violation removes the substituted pattern from the delay line
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               lastpos_q <= 1'b0;
               dly_q     <= 4'h0;
               kill_q    <= 1'b0;
               ais_ph_q  <= 1'b0;
            end else if (stb) begin
               ais_ph_q <= ~ais_ph_q;
               if (bpos | bneg) begin
                  lastpos_q <= bpos;
               end
               if (!ami && viol) begin
                  dly_q  <= 4'h0;
                  kill_q <= gcfg_q.t1;
               end else begin
                  dly_q  <= {dly_q[2:0], (bpos | bneg) & ~kill_q};
                  kill_q <= 1'b0;
               end
            end
         end

         always_comb begin
            o_d = '0;
            if (raw) begin
               o_d.pos  = pos_s[g];
               o_d.neg  = neg_s[g];
               o_d.rclk = pos_s[g] ^ neg_s[g];
            end else if (los_w[g] && gcfg_q.ais_en) begin
               o_d.rclk   = mclk_s;
               o_d.pos    = !single & ais_ph_q;
               o_d.neg    = !single & ~ais_ph_q;
               o_d.single = single;
            end else begin
               o_d.rclk = rclk_rec;
               if (single) begin
                  o_d.single = ami ? dly_q[0] : dly_q[3];
               end else begin
                  o_d.pos = bpos;
                  o_d.neg = bneg;
               end
            end
         end

         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               recovered_clock_out[g] <= 1'b0;
               rx_positive_out[g]     <= 1'b0;
               rx_negative_out[g]     <= 1'b0;
               rx_single_data_out[g]  <= 1'b0;
               loss_of_signal_out[g]  <= 1'b0;
            end else begin
               recovered_clock_out[g] <= o_d.rclk;
               rx_positive_out[g]     <= o_d.pos;
               rx_negative_out[g]     <= o_d.neg;
               rx_single_data_out[g]  <= o_d.single;
               loss_of_signal_out[g]  <= los_w[g];
            end
         end
      end
   endgenerate
endmodule

// file: inc/rxr_pkg.sv
// rxr_pkg: constants, register map and carrier types of the receive recovery block
// assumes: 8-bit register port, four channels, 40 MHz system clock
package rxr_pkg;
   localparam int          NCH                      = 4;
   localparam int          ADDR_W                   = 3;
   localparam int          DATA_W                   = 8;
   // register offsets
   localparam logic [2:0]  REG_GLOBAL_CONFIG        = 3'h0;
   localparam logic [2:0]  REG_RECOVERY_SELECT      = 3'h1;
   localparam logic [2:0]  REG_SINGLE_RAIL_OVERRIDE = 3'h2;
   localparam logic [2:0]  REG_CHANNEL_CODE         = 3'h3;
   localparam logic [2:0]  REG_LOS_STATUS           = 3'h4;
   localparam logic [2:0]  REG_INT_STATUS           = 3'h5;
   localparam logic [2:0]  REG_INT_CLEAR            = 3'h6;
   localparam logic [2:0]  REG_INT_ENABLE           = 3'h7;
   // global config field positions
   localparam int          GCF_CODE_POS             = 0;
   localparam int          GCF_ETSI_POS             = 1;
   localparam int          GCF_T1_POS               = 2;
   localparam int          GCF_AIS_POS              = 3;
   // reset values
   localparam logic [7:0]  GCF_RESET                = 8'h00;
   localparam logic [3:0]  CH_RESET                 = 4'h0;
   // recovery loop timing
   localparam int          OVERSAMPLE               = 16;
   localparam logic [3:0]  SAMPLE_PHASE             = 4'h8;
   // loss detection figures
   localparam logic [11:0] T1_LOS_RUN               = 12'h0af;  // 175
   localparam logic [11:0] G775_LOS_RUN             = 12'h020;  // 32
   localparam logic [11:0] ETSI_LOS_RUN             = 12'h800;  // 2048
   localparam logic [7:0]  T1_WIN                   = 8'h80;    // 128
   localparam logic [7:0]  E1_WIN                   = 8'h20;    // 32
   localparam logic [7:0]  T1_MARKS                 = 8'h10;    // 16
   localparam logic [7:0]  E1_MARKS                 = 8'h04;    // 4
   localparam logic [11:0] T1_MAX_ZEROS             = 12'h063;  // 99
   localparam logic [11:0] E1_MAX_ZEROS             = 12'h00f;  // 15
   localparam logic [4:0]  TDN_HIGH_EDGES           = 5'h10;    // 16
   localparam int          MCLK_STUCK_CYCLES        = 64;

   typedef struct packed {
      logic ais_en;
      logic t1;
      logic etsi;
      logic code;
   } rxr_gcfg_s;

   typedef struct packed {
      logic rclk;
      logic pos;
      logic neg;
      logic single;
   } rxr_chout_s;
endpackage

// file: logic/rxr_cdr.sv
// rxr_cdr: one channel of the digital recovery loop, 16 phases per bit
// assumes: tick is a one-cycle pulse per oversampling clock edge, pos/neg already synchronised
`timescale 1ns/1ps
module rxr_cdr (
   // clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   // oversampling tick and sliced line
   input  wire logic tick,
   input  wire logic pos,
   input  wire logic neg,
   // recovered bit
   output logic      bit_stb,
   output logic      bit_pos,
   output logic      bit_neg,
   output logic      rclk
);
   import rxr_pkg::*;

   logic [3:0] phase_q;
   logic       prev_any_q;
   logic       pend_pos_q;
   logic       pend_neg_q;
   logic       any_w;
   logic       smp_w;

   assign any_w = pos | neg;
   assign smp_w = tick && (phase_q == SAMPLE_PHASE);

   // phase restarts on each pulse leading edge, otherwise free runs
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         phase_q    <= 4'h0;
         prev_any_q <= 1'b0;
      end else if (tick) begin
         prev_any_q <= any_w;
         if (any_w && !prev_any_q) begin
            phase_q <= 4'h1;
         end else begin
            phase_q <= phase_q + 4'h1;
         end
      end
   end

   // pulses seen during the bit are held until the mid-bit sample
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pend_pos_q <= 1'b0;
         pend_neg_q <= 1'b0;
      end else if (smp_w) begin
         pend_pos_q <= 1'b0;
         pend_neg_q <= 1'b0;
      end else begin
         pend_pos_q <= pend_pos_q | pos;
         pend_neg_q <= pend_neg_q | neg;
      end
   end

   // retimed nrz bit and recovered clock
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bit_stb <= 1'b0;
         bit_pos <= 1'b0;
         bit_neg <= 1'b0;
         rclk    <= 1'b0;
      end else begin
         bit_stb <= smp_w;
         rclk    <= (phase_q < SAMPLE_PHASE);
         if (smp_w) begin
            bit_pos <= pend_pos_q | pos;
            bit_neg <= pend_neg_q | neg;
         end
      end
   end
endmodule

// file: logic/rxr_los.sv
// rxr_los: loss of signal detect and density based clearing for one channel
// assumes: bit_stb marks one recovered bit, mark is valid beside it
`timescale 1ns/1ps
module rxr_los (
   // clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   // criterion selection
   input  wire logic t1,
   input  wire logic etsi,
   // recovered bits
   input  wire logic bit_stb,
   input  wire logic mark,
   // state
   output logic      los
);
   import rxr_pkg::*;

   logic [127:0] hist_q;
   logic [11:0]  zrun_q;
   logic [11:0]  zrun_d;
   logic [15:0]  marks_q;
   logic [15:0]  marks_d;
   logic [7:0]   clean_q;
   logic [7:0]   clean_d;
   logic [11:0]  run_len;
   logic [11:0]  max_z;
   logic [7:0]   win;
   logic [7:0]   need;

   always_comb begin
      run_len = t1 ? T1_LOS_RUN : (etsi ? ETSI_LOS_RUN : G775_LOS_RUN);
      win     = t1 ? T1_WIN : E1_WIN;
      need    = t1 ? T1_MARKS : E1_MARKS;
      max_z   = t1 ? T1_MAX_ZEROS : E1_MAX_ZEROS;
      zrun_d  = mark ? 12'h000 : ((zrun_q == 12'hfff) ? zrun_q : zrun_q + 12'h001);
      // low byte 32-bit window, high 128-bit
      marks_d = marks_q + {7'h00, mark, 7'h00, mark} - {7'h00, hist_q[127], 7'h00, hist_q[31]};
      // bits since the last zero run that went beyond the limit
      if (zrun_d > max_z) begin
         clean_d = 8'h00;
      end else begin
         clean_d = (clean_q == 8'hff) ? clean_q : clean_q + 8'h01;
      end
   end

   // counting advances once per recovered bit
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hist_q  <= '0;
         zrun_q  <= 12'h000;
         marks_q <= 16'h0000;
         clean_q <= 8'h00;
      end else if (bit_stb) begin
         hist_q  <= {hist_q[126:0], mark};
         zrun_q  <= zrun_d;
         marks_q <= marks_d;
         clean_q <= clean_d;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         los <= 1'b0;
      end else if (bit_stb) begin
         if (!los && zrun_d >= run_len) begin
            los <= 1'b1;
         end else if (los && (t1 ? marks_d[15:8] : marks_d[7:0]) >= need && clean_d >= win) begin
            los <= 1'b0;
         end
      end
   end
endmodule

// file: dv/rxr_top_sva.sv
// rxr_top_sva: port level checks of the receive recovery block
// assumes: bound into rxr_top, one clock domain, master clock ticks slower than clk
`timescale 1ns/1ps
module rxr_top_sva #(
   parameter int MCLK_STUCK = rxr_pkg::MCLK_STUCK_CYCLES
) (
   // clock and reset
   input wire logic                       clk,
   input wire logic                       nrst,
   // register port
   input wire logic [rxr_pkg::ADDR_W-1:0] addr,
   input wire logic [rxr_pkg::DATA_W-1:0] wdata,
   input wire logic                       wr,
   input wire logic                       rd,
   input wire logic [rxr_pkg::DATA_W-1:0] rdata,
   // line side inputs
   input wire logic                       master_clock_in,
   input wire logic [rxr_pkg::NCH-1:0]    slicer_pos_in,
   input wire logic [rxr_pkg::NCH-1:0]    slicer_neg_in,
   // outputs
   input wire logic [rxr_pkg::NCH-1:0]    recovered_clock_out,
   input wire logic [rxr_pkg::NCH-1:0]    rx_positive_out,
   input wire logic [rxr_pkg::NCH-1:0]    rx_negative_out,
   input wire logic [rxr_pkg::NCH-1:0]    rx_single_data_out,
   input wire logic [rxr_pkg::NCH-1:0]    loss_of_signal_out,
   input wire logic                       irq
);
   import rxr_pkg::*;
   logic [7:0]  en_q;
   logic [3:0]  sel_q;
   logic        mc_q;
   logic [11:0] quiet_q;
   logic [7:0]  mc_hi_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // shadow copies of the enable and recovery select registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         en_q  <= 8'h00;
         sel_q <= 4'h0;
      end else if (wr && addr == REG_INT_ENABLE) begin
         en_q <= wdata;
      end else if (wr && addr == REG_RECOVERY_SELECT) begin
         sel_q <= wdata[3:0];
      end
   end
   // oversample ticks since the last pulse on channel 0, cycles the master clock sat high
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mc_q    <= 1'b0;
         quiet_q <= 12'h000;
         mc_hi_q <= 8'h00;
      end else begin
         mc_q    <= master_clock_in;
         mc_hi_q <= !master_clock_in ? 8'h00 : (mc_hi_q == 8'hff ? mc_hi_q : mc_hi_q + 8'h01);
         if (slicer_pos_in[0] || slicer_neg_in[0]) quiet_q <= 12'h000;
         else if (master_clock_in && !mc_q && quiet_q != 12'hfff) quiet_q <= quiet_q + 12'h001;
      end
   end
   sequence en_off_s;
      (wr && addr == REG_INT_ENABLE && wdata == 8'h00) ##1 !(wr && addr == REG_INT_ENABLE);
   endsequence
   rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data not zero outside a read");
   clear_read_a: assert property (rd && addr == REG_INT_CLEAR |=> rdata == 8'h00)
      else $error("clear register read back nonzero");
   irq_enable_a: assert property (irq |-> $past(en_q) != 8'h00)
      else $error("interrupt high with every source masked");
   irq_off_a: assert property (en_off_s |=> !irq)
      else $error("interrupt still high after masking");
   loss_hold_a: assert property ($rose(loss_of_signal_out[0]) |-> loss_of_signal_out[0] [*8])
      else $error("loss output did not hold");
   loss_quiet_a: assert property ($rose(loss_of_signal_out[0]) |-> quiet_q >= 12'd480)
      else $error("loss declared with recent pulses");
   loss_clear_a: assert property ($fell(loss_of_signal_out[0]) |-> quiet_q < 12'd1650)
      else $error("loss cleared without recent marks");
   raw_xor_a: assert property (sel_q[0] && $past(sel_q[0], 2) && !loss_of_signal_out[0]
      && !$past(loss_of_signal_out[0]) |-> recovered_clock_out[0] == (rx_positive_out[0] ^ rx_negative_out[0])
      && !rx_single_data_out[0]) else $error("raw mode clock is not the xor of the rails");
   mclk_raw_a: assert property (mc_hi_q > MCLK_STUCK + 8 && loss_of_signal_out == 4'h0
      && $past(loss_of_signal_out) == 4'h0 |-> recovered_clock_out == (rx_positive_out ^ rx_negative_out)
      && rx_single_data_out == 4'h0) else $error("held master clock did not force raw mode");
   rail_excl_a: assert property ((rx_single_data_out & (rx_positive_out | rx_negative_out)) == 4'h0)
      else $error("single and dual rail outputs active together");
endmodule
bind rxr_top rxr_top_sva #(.MCLK_STUCK(MCLK_STUCK)) u_sva (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata,
   .master_clock_in, .slicer_pos_in, .slicer_neg_in, .recovered_clock_out, .rx_positive_out, .rx_negative_out,
   .rx_single_data_out, .loss_of_signal_out, .irq);

// file: dv/rxr_framer_model.sv
// rxr_framer_model: system side framer driving transmit clock and negative data pins
// assumes: dual rail traffic toggles the negative pin, single rail request holds it high
`timescale 1ns/1ps
module rxr_framer_model (
   // link clock
   output logic                       tx_clock,
   // transmit negative data per channel
   output logic [rxr_pkg::NCH-1:0]    tx_negative,
   // mode request per channel
   input  wire logic [rxr_pkg::NCH-1:0] single_rail
);
   import rxr_pkg::*;
   logic toggle = 1'b0;
   // free running, phase unrelated to the system clock
   initial begin
      tx_clock = 1'b0;
      #37;
      forever #100 tx_clock = ~tx_clock;
   end
   always @(posedge tx_clock) begin
      toggle <= ~toggle;
   end
   // pulsing never stays high two cycles; a single rail request stays high throughout
   assign tx_negative = single_rail | {NCH{toggle}};
endmodule

// file: dv/rxr_top_test.sv
// rxr_top_test: register and line level tests of the receive recovery block
// assumes: rxr_top with a short stuck count, framer model on the transmit pins
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; $display("[FAIL] %0t got %h want %h", $time, a, e); end end
module rxr_top_test;
   import rxr_pkg::*;
   localparam int BIT = 64;
   logic              clk = 1'b0;
   logic              nrst = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic              wr = 1'b0;
   logic              rd = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic              master_clock_in = 1'b0;
   logic              hold_mc = 1'b0, hw = 1'b0;
   logic              pol = 1'b0;
   logic [NCH-1:0]    pos = '0, neg = '0, single_rail = '0, tx_negative, rclk, rpos, rneg, rsing, los;
   logic              tx_clock, irq;
   int                fails = 0, comparisons = 0, cyc = 0, bitcnt = 0, ph = 0, every = 1, took, n, k;
   rxr_top #(.MCLK_STUCK(16)) DUT (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .hw_mode_in(hw),
      .code_pin_in(1'b0), .master_clock_in, .slicer_pos_in(pos), .slicer_neg_in(neg), .tx_clock_in(tx_clock),
      .tx_negative_in(tx_negative), .recovered_clock_out(rclk), .rx_positive_out(rpos),
      .rx_negative_out(rneg), .rx_single_data_out(rsing), .loss_of_signal_out(los), .irq);
   rxr_framer_model FRAMER (.tx_clock, .tx_negative, .single_rail);
   initial forever #12.5 clk = ~clk;
   // master clock of 4 clk per tick, 16 ticks per line bit, alternate mark pulses of half a bit
   always @(posedge clk) begin
      cyc <= cyc + 1;
      master_clock_in <= hold_mc | ph[1];
      ph <= (ph == BIT - 1) ? 0 : ph + 1;
      if (ph == 0) begin
         bitcnt <= bitcnt + 1;
         if (every != 0 && bitcnt % every == 0) begin
            pos <= {NCH{~pol}};
            neg <= {NCH{pol}};
            pol <= ~pol;
         end
      end else if (ph == BIT / 2) begin
         pos <= '0;
         neg <= '0;
      end
      if (cyc == 60000) begin
         fails++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 `CHK(rdata, e)
   endtask
   task automatic wait_bits(input int b);
      repeat (b * BIT) @(posedge clk);
      #1;
   endtask
   task automatic wait_los(input logic lvl, input int maxbits);
      int start;
      start = bitcnt;
      n = 0;
      while (los[0] !== lvl && n < maxbits * BIT) begin
         @(posedge clk);
         n++;
      end
      #1;
      took = bitcnt - start;
   endtask
   task automatic count_rclk(input int nclk);
      logic prev;
      n = 0;
      prev = rclk[0];
      repeat (nclk) begin
         @(posedge clk);
         #1;
         if (rclk[0] === 1'b1 && prev === 1'b0) n++;
         prev = rclk[0];
      end
   endtask
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      for (int a = 0; a < 8; a++) rd_chk(3'(a), 8'h00);
      wr_reg(REG_LOS_STATUS, 8'h0f);
      rd_chk(REG_LOS_STATUS, 8'h00);
      wr_reg(REG_SINGLE_RAIL_OVERRIDE, 8'h05);
      rd_chk(REG_SINGLE_RAIL_OVERRIDE, 8'h05);
      wr_reg(REG_SINGLE_RAIL_OVERRIDE, 8'h00);
      wr_reg(REG_INT_ENABLE, 8'hff);
      every <= 0;
      wait_los(1'b1, 40);
      `CHK(took >= 31 && took <= 34, 1'b1)
      wait_bits(0);
      repeat (4) @(posedge clk);
      #1 `CHK({irq, los}, 5'h1f)
      rd_chk(REG_LOS_STATUS, 8'h0f);
      rd_chk(REG_INT_STATUS, 8'h0f);
      wr_reg(REG_INT_ENABLE, 8'h00);
      repeat (2) @(posedge clk);
      #1 `CHK(irq, 1'b0)
      wr_reg(REG_INT_ENABLE, 8'hff);
      wr_reg(REG_INT_CLEAR, 8'hff);
      rd_chk(REG_INT_STATUS, 8'h00);
      `CHK(irq, 1'b0)
      every <= 1;
      wait_bits(3);
      `CHK(los[0], 1'b1)
      wait_los(1'b0, 40);
      `CHK(los[0], 1'b0)
      rd_chk(REG_INT_STATUS, 8'hf0);
      wr_reg(REG_INT_CLEAR, 8'hff);
      wr_reg(REG_GLOBAL_CONFIG, 8'(1 << GCF_T1_POS));
      every <= 0;
      wait_los(1'b1, 180);
      `CHK(took >= 174 && took <= 177, 1'b1)
      every <= 8;
      wait_los(1'b0, 200);
      `CHK(took >= 110 && took < 200, 1'b1)
      wr_reg(REG_GLOBAL_CONFIG, 8'(1 << GCF_ETSI_POS));
      every <= 0;
      wait_bits(40);
      `CHK(los[0], 1'b0)
      hw <= 1'b1;
      wait_bits(2);
      `CHK(los[0], 1'b1)
      wr_reg(REG_GLOBAL_CONFIG, 8'(1 << GCF_AIS_POS));
      count_rclk(16 * BIT);
      `CHK(n > 200, 1'b1)
      wr_reg(REG_GLOBAL_CONFIG, 8'h00);
      count_rclk(16 * BIT);
      `CHK(n < 40, 1'b1)
      every <= 1;
      wait_los(1'b0, 40);
      wr_reg(REG_RECOVERY_SELECT, 8'h01);
      wait_bits(8);
      wr_reg(REG_RECOVERY_SELECT, 8'h00);
      hold_mc <= 1'b1;
      wait_bits(6);
      hold_mc <= 1'b0;
      single_rail <= 4'h2;
      wait_bits(10);
      n = 0;
      k = 0;
      repeat (8 * BIT) begin
         @(posedge clk);
         #1;
         n += rsing[1];
         k += rpos[1] | rneg[1];
      end
      `CHK(n > 0 && k == 0, 1'b1)
      end_of_test();
   end
endmodule
